// ---- dv/tcr_tb.sv ----
// Self-checking testbench for the timer count readback slave.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, pce, psel, penable, pwrite, run, stall;
   logic [11:0] paddr;
   logic [31:0] pwdata, d;
   wire [31:0] prdata;
   wire pready, pslverr, cap1, cap3, irq;
   logic [15:0] cnt [4] = '{default: 16'h0000};
   logic [15:0] rlm [4];
   wire [15:0] rl [4];
   logic [7:0] hold [4];
   logic [3:0] eoc, pin;
   logic [32:0] q [$];
   logic [11:0] lo_a [4] = '{12'h18C, 12'h1A0, 12'h1C8, 12'h1DC};
   logic [11:0] hi_a [4] = '{12'h190, 12'h1A4, 12'h1CC, 12'h1E0};
   int err_count, check_count, i, b;
   int cap_n [2];
   tcr_top dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_t0(cnt[0]), .count_t1(cnt[1]), .count_t2(cnt[2]),
      .count_t3(cnt[3]), .eoc_t0(eoc[0]), .eoc_t1(eoc[1]), .eoc_t2(eoc[2]), .eoc_t3(eoc[3]),
      .first_capture_pin(pin[0]), .third_capture_pin(pin[1]), .trip_t1_pin(pin[2]),
      .trip_t3_pin(pin[3]), .reload_t0(rl[0]), .reload_t1(rl[1]), .reload_t2(rl[2]),
      .reload_t3(rl[3]), .capture_a_t1(cap1), .capture_a_t3(cap3), .irq(irq));
   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp=%h got=%h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // The expected count is taken at the falling edge, before the setup edge samples it.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(negedge pclk);
      for (int k = 0; k < 4; k++) begin
         if (!w && a == lo_a[k]) begin
            e = {25'h0000000, cnt[k][7:0]};
            hold[k] = cnt[k][15:8];
         end
         if (!w && a == hi_a[k]) e = {25'h0000000, hold[k]};
         if (w && a == lo_a[k]) rlm[k][7:0] = wd[7:0];
         if (w && a == hi_a[k]) rlm[k][15:8] = wd[7:0];
      end
      q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      pce <= !stall;
      do begin
         @(posedge pclk);
         pce <= 1'b1;
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         d = q[0][31:0];
         chk("apb", q.pop_front(), {pslverr, pwrite ? d : prdata});
      end
      if (run) for (int k = 0; k < 4; k++) cnt[k] <= cnt[k] + 16'($urandom_range(300));
   end
   // Each capture strobe must last exactly one cycle, so high cycles are counted.
   always @(posedge pclk) begin
      if (cap1) cap_n[0]++;
      if (cap3) cap_n[1]++;
   end
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #400000;
      err_count++;
      summarize();
   end
   initial begin
      {presetn, pce, psel, penable, pwrite, run, stall, paddr, pwdata} = '0;
      rlm = '{default: 16'h0000};
      {eoc, pin} = 8'h00;
      void'($urandom(74));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      pce <= 1'b1;
      for (i = 0; i < 4; i++) xfer(1'b0, lo_a[i], 0, 0);
      for (i = 0; i < 4; i++) xfer(1'b0, hi_a[i], 0, 0);
      run <= 1'b1;
      repeat (30) begin
         i = $urandom_range(3);
         stall = 1'($urandom_range(1));
         xfer(1'b0, lo_a[i], 0, 0);
         xfer(1'b1, $urandom_range(1) ? lo_a[i] : hi_a[i], $urandom, 0);
         xfer(1'b0, hi_a[i], 0, 0);
         @(negedge pclk) chk("reload", {17'h00000, rlm[i]}, {17'h00000, rl[i]});
      end
      stall = 1'b0;
      xfer(1'b0, 12'h000, 0, 33'h100000000);
      xfer(1'b1, 12'h3FC, 32'h000000FF, 33'h100000000);
      xfer(1'b1, 12'h204, 32'h0000003F, 0);
      // Ends of count first, then both capture pins and both trip pins.
      for (i = 0; i < 8; i++) begin
         b = i < 4 ? i : 4 + i % 2;
         @(posedge pclk) if (i < 4) eoc[i] <= 1'b1; else pin[i-4] <= 1'b1;
         repeat (i < 4 ? 1 : 6) @(posedge pclk);
         {eoc, pin} <= 8'h00;
         @(negedge pclk) chk("irq", 33'h1, {32'h0, irq});
         chk("capa", 33'(i < 4 ? 0 : i / 2 - 1), 33'(cap_n[i % 2]));
         xfer(1'b0, 12'h200, 0, 33'h1 << b);
         xfer(1'b1, 12'h200, 32'h0000003F, 0);
         xfer(1'b0, 12'h200, 0, 0);
         chk("irq", 33'h0, {32'h0, irq});
      end
      xfer(1'b1, 12'h204, 0, 0);
      @(posedge pclk) eoc[0] <= 1'b1;
      @(posedge pclk) eoc[0] <= 1'b0;
      @(negedge pclk) chk("irq", 33'h0, {32'h0, irq});
      xfer(1'b0, 12'h200, 0, 33'h1);
      repeat (2) @(posedge pclk);
      summarize();
   end
endmodule // tb

// ---- dv/tcr_top_checker.sv ----
// Assertion checker for the timer count readback slave, bound to its top module.
`include "tcr_consts.vh"
module tcr_top_checker (
   input logic pclk,
   input logic presetn,
   input logic pce,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [`TCR_ADDR_W-1:0] paddr,
   input logic [`TCR_DATA_W-1:0] pwdata,
   input logic [`TCR_DATA_W-1:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic [`TCR_CNT_W-1:0] count_t0,
   input logic eoc_t0,
   input logic first_capture_pin,
   input logic trip_t3_pin,
   input logic [`TCR_CNT_W-1:0] reload_t0,
   input logic capture_a_t1,
   input logic capture_a_t3,
   input logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [`TCR_EV_W-1:0] mask_q;
   logic [`TCR_BYTE_W-1:0] snap_q;
   wire rd_setup = psel && !penable && pce && !pwrite;
   wire wr_done = psel && penable && pready && pwrite;
   // Shadows of internal state, since the checker sees only the ports.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `TCR_EV_ZERO;
         snap_q <= `TCR_BYTE_ZERO;
      end else begin
         if (wr_done && paddr == 12'h204) mask_q <= pwdata[`TCR_EV_W-1:0];
         if (rd_setup && paddr == 12'h18C) snap_q <= count_t0[15:8];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_lo_rd; rd_setup && paddr == 12'h18C; endsequence
   sequence s_hi_rd; rd_setup && paddr == 12'h190; endsequence
   sequence s_setup; psel && !penable && pce; endsequence
   a_zero_wait: assert property (s_setup ##1 (psel && penable && pce) |-> pready)
      else $error("wait state inserted");
   a_ready_phase: assert property (pready |-> psel && penable && pce)
      else $error("ready outside access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_low_read: assert property (s_lo_rd |=> prdata[7:0] == $past(count_t0[7:0])
      && prdata[31:8] == 24'h000000) else $error("low byte wrong");
   a_high_snap: assert property (s_hi_rd |=> prdata == {`TCR_PAD_ZERO, snap_q})
      else $error("high byte not snapshot");
   a_reload_only: assert property (wr_done && paddr == 12'h18C |=>
      reload_t0 == {$past(reload_t0[15:8]), $past(pwdata[7:0])}) else $error("reload wrong");
   a_eoc_irq: assert property (eoc_t0 && pce && mask_q[0] |=> irq)
      else $error("end of count lost");
   a_irq_masked: assert property (mask_q == 6'h00 |-> !irq)
      else $error("irq while masked");
   a_cap_pulse: assert property (disable iff (!presetn || !pce)
      $rose(first_capture_pin) |-> ##[2:5] capture_a_t1) else $error("capture lost");
   a_trip_pulse: assert property (disable iff (!presetn || !pce)
      $rose(trip_t3_pin) |-> ##[2:5] capture_a_t3) else $error("trip lost");
endmodule // tcr_top_checker

bind tcr_top tcr_top_checker u_chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .count_t0, .eoc_t0, .first_capture_pin, .trip_t3_pin,
   .reload_t0, .capture_a_t1, .capture_a_t3, .irq);

// ---- rtl/tcr_snap.v ----
// Per-timer holding register for the high count byte and the write-only reload value.
`include "tcr_consts.vh"

module tcr_snap (
   input wire pclk,
   input wire presetn,
   input wire pce,
   input wire lo_rd,
   input wire lo_wr,
   input wire hi_wr,
   input wire [`TCR_BYTE_W-1:0] wbyte,
   input wire [`TCR_CNT_W-1:0] count,
   output wire [`TCR_BYTE_W-1:0] hold,
   output wire [`TCR_CNT_W-1:0] reload
);

   reg [`TCR_BYTE_W-1:0] hold_q;
   reg [`TCR_CNT_W-1:0] reload_q;

   // The high byte is frozen at the very edge the low byte is taken, so a
   // carry between the two reads cannot tear the 16-bit value.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= `TCR_BYTE_ZERO;
      end else if (pce && lo_rd) begin
         hold_q <= count[`TCR_CNT_W-1:`TCR_BYTE_W];
      end
   end

   // Writes at the shared addresses land here and never in the running count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_q <= `TCR_CNT_ZERO;
      end else if (pce) begin
         if (lo_wr) begin
            reload_q[`TCR_BYTE_W-1:0] <= wbyte;
         end
         if (hi_wr) begin
            reload_q[`TCR_CNT_W-1:`TCR_BYTE_W] <= wbyte;
         end
      end
   end

   assign hold = hold_q;
   assign reload = reload_q;

endmodule // tcr_snap

// ---- rtl/tcr_top.v ----
// Timer count readback, capture A and end-of-count flags, and their APB register slave.
`include "tcr_consts.vh"

module tcr_top (
   input wire pclk,
   input wire presetn,
   input wire pce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`TCR_ADDR_W-1:0] paddr,
   input wire [`TCR_DATA_W-1:0] pwdata,
   output wire [`TCR_DATA_W-1:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [`TCR_CNT_W-1:0] count_t0,
   input wire [`TCR_CNT_W-1:0] count_t1,
   input wire [`TCR_CNT_W-1:0] count_t2,
   input wire [`TCR_CNT_W-1:0] count_t3,
   input wire eoc_t0,
   input wire eoc_t1,
   input wire eoc_t2,
   input wire eoc_t3,
   input wire first_capture_pin,
   input wire third_capture_pin,
   input wire trip_t1_pin,
   input wire trip_t3_pin,
   output wire [`TCR_CNT_W-1:0] reload_t0,
   output wire [`TCR_CNT_W-1:0] reload_t1,
   output wire [`TCR_CNT_W-1:0] reload_t2,
   output wire [`TCR_CNT_W-1:0] reload_t3,
   output wire capture_a_t1,
   output wire capture_a_t3,
   output wire irq
);

   localparam NT = `TCR_NUM;
   localparam CW = `TCR_CNT_W;
   localparam BW = `TCR_BYTE_W;
   localparam DW = `TCR_DATA_W;
   localparam IW = `TCR_IDX_W;
   localparam EW = `TCR_EV_W;
   localparam [NT*IW-1:0] LO_IDX = `TCR_LO_IDX_ALL;
   localparam [NT*IW-1:0] HI_IDX = `TCR_HI_IDX_ALL;

   // ------------------------------------------------------------------
   // Timer-side inputs gathered into vectors so one loop serves all timers.
   // ------------------------------------------------------------------

   wire [NT*CW-1:0] cnt_all;
   wire [NT*CW-1:0] rl_all;
   wire [NT-1:0] eoc_all;

   assign cnt_all = {count_t3, count_t2, count_t1, count_t0};
   assign eoc_all = {eoc_t3, eoc_t2, eoc_t1, eoc_t0};

   // ------------------------------------------------------------------
   // Pin synchronisers. The capture and trip pins are asynchronous to pclk,
   // so each passes two flops before anything looks at it; the third flop
   // only provides the previous value for edge detection.
   // ------------------------------------------------------------------

   wire [`TCR_PIN_W-1:0] pin_raw;
   reg [`TCR_PIN_W-1:0] pin_meta_q;
   reg [`TCR_PIN_W-1:0] pin_sync_q;
   reg [`TCR_PIN_W-1:0] pin_prev_q;
   wire [`TCR_PIN_W-1:0] pin_rise;

   assign pin_raw = {trip_t3_pin, trip_t1_pin, third_capture_pin, first_capture_pin};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= `TCR_PIN_ZERO;
         pin_sync_q <= `TCR_PIN_ZERO;
         pin_prev_q <= `TCR_PIN_ZERO;
      end else if (pce) begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   // Only rising edges count; edge selection belongs to the capture control
   // logic elsewhere, which can qualify these pulses further.
   assign pin_rise = pin_sync_q & ~pin_prev_q;

   // ------------------------------------------------------------------
   // Capture A events. A power trip raises the same flag as a capture,
   // since both demand the same software attention.
   // ------------------------------------------------------------------

   wire capa_t1_ev;
   wire capa_t3_ev;
   reg capa_t1_q;
   reg capa_t3_q;

   assign capa_t1_ev = pin_rise[`TCR_PIN_CAP_T1] | pin_rise[`TCR_PIN_TRIP_T1];
   assign capa_t3_ev = pin_rise[`TCR_PIN_CAP_T3] | pin_rise[`TCR_PIN_TRIP_T3];

   // Registered copies go to the capture value logic as one-cycle strobes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capa_t1_q <= 1'b0;
         capa_t3_q <= 1'b0;
      end else if (pce) begin
         capa_t1_q <= capa_t1_ev;
         capa_t3_q <= capa_t3_ev;
      end
   end

   assign capture_a_t1 = capa_t1_q;
   assign capture_a_t3 = capa_t3_q;

   // ------------------------------------------------------------------
   // APB front end. The read value is taken at the setup edge and shown in
   // the access phase, so every transfer completes without wait states
   // unless the clock enable stalls it.
   // ------------------------------------------------------------------

   wire [IW-1:0] idx;
   wire setup;
   wire wr_done;
   reg acc_q;
   reg [DW-1:0] prdata_q;
   reg err_q;

   assign idx = paddr[`TCR_IDX_MSB:`TCR_IDX_LSB];
   assign setup = psel & ~penable & pce;
   assign pready = psel & penable & acc_q & pce;
   assign wr_done = pready & pwrite;

   wire stat_hit;
   wire mask_hit;
   wire [NT-1:0] lo_hit;
   wire [NT-1:0] hi_hit;
   wire any_hit;

   assign stat_hit = (idx == `TCR_STAT_IDX);
   assign mask_hit = (idx == `TCR_MASK_IDX);
   assign any_hit = stat_hit | mask_hit | (|lo_hit) | (|hi_hit);

   // ------------------------------------------------------------------
   // Event status, mask and interrupt.
   // ------------------------------------------------------------------

   reg [EW-1:0] stat_q;
   reg [EW-1:0] stat_d;
   reg [EW-1:0] mask_q;
   wire [EW-1:0] ev;
   wire [EW-1:0] clr;

   assign ev = {capa_t3_ev, capa_t1_ev, eoc_all};
   assign clr = (wr_done && stat_hit) ? pwdata[EW-1:0] : `TCR_EV_ZERO;

   // A new event in the cycle of its clear survives: the set is applied last.
   always @* begin
      stat_d = (stat_q & ~clr) | ev;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= `TCR_EV_ZERO;
         mask_q <= `TCR_EV_ZERO;
      end else if (pce) begin
         stat_q <= stat_d;
         if (wr_done && mask_hit) begin
            mask_q <= pwdata[EW-1:0];
         end
      end
   end

   assign irq = |(stat_q & mask_q);

   // ------------------------------------------------------------------
   // Per-timer decode, snapshot and reload storage.
   // ------------------------------------------------------------------

   wire [NT*BW-1:0] hold_all;
   wire [(NT+1)*DW-1:0] rd_chain;

   assign rd_chain[DW-1:0] = `TCR_WORD_ZERO;

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi = gi + 1) begin : g_tmr
         wire [CW-1:0] cnt;
         wire [BW-1:0] hold;
         wire [DW-1:0] term;

         assign cnt = cnt_all[gi*CW +: CW];

         // Count and reload share each address; direction picks the target.
         assign lo_hit[gi] = (idx == LO_IDX[gi*IW +: IW]);
         assign hi_hit[gi] = (idx == HI_IDX[gi*IW +: IW]);

         // The snapshot is the only state a read touches, so counting and
         // reloading go on undisturbed.
         tcr_snap u_snap (
            .pclk(pclk),
            .presetn(presetn),
            .pce(pce),
            .lo_rd(setup & ~pwrite & lo_hit[gi]),
            .lo_wr(wr_done & lo_hit[gi]),
            .hi_wr(wr_done & hi_hit[gi]),
            .wbyte(pwdata[BW-1:0]),
            .count(cnt),
            .hold(hold),
            .reload(rl_all[gi*CW +: CW])
         );

         assign hold_all[gi*BW +: BW] = hold;

         // Reads at the shared addresses always return count data. The high
         // byte is only coherent if software took the low byte first.
         assign term = lo_hit[gi] ? {`TCR_PAD_ZERO, cnt[BW-1:0]} :
                       hi_hit[gi] ? {`TCR_PAD_ZERO, hold_all[gi*BW +: BW]} :
                       `TCR_WORD_ZERO;

         assign rd_chain[(gi+1)*DW +: DW] = rd_chain[gi*DW +: DW] | term;
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read data and response capture.
   // ------------------------------------------------------------------

   reg [DW-1:0] rd_mux;

   always @* begin
      rd_mux = rd_chain[NT*DW +: DW];
      if (stat_hit) begin
         rd_mux = {`TCR_EV_PAD, stat_q};
      end else if (mask_hit) begin
         rd_mux = {`TCR_EV_PAD, mask_q};
      end
   end

   // Unmapped addresses answer with an error and read as zero; the data
   // register resets to zero so prdata reads clear until the first read.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 1'b0;
         prdata_q <= `TCR_WORD_ZERO;
         err_q <= 1'b0;
      end else if (pce) begin
         if (setup) begin
            acc_q <= 1'b1;
            err_q <= ~any_hit;
            if (!pwrite) begin
               prdata_q <= rd_mux;
            end
         end else if (pready) begin
            acc_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pready & err_q;

   assign reload_t0 = rl_all[0*CW +: CW];
   assign reload_t1 = rl_all[1*CW +: CW];
   assign reload_t2 = rl_all[2*CW +: CW];
   assign reload_t3 = rl_all[3*CW +: CW];

endmodule // tcr_top

// ---- shared/tcr_consts.vh ----
// Constants for the timer count readback block: register indices, field layout and reset values.
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

// Number of timers served by the block.
`define TCR_NUM 4

// Register indices; the byte address on the bus is four times the index.
`define TCR_IDX_W 10
`define TCR_LO_IDX_ALL {10'h077, 10'h072, 10'h068, 10'h063}
`define TCR_HI_IDX_ALL {10'h078, 10'h073, 10'h069, 10'h064}
`define TCR_STAT_IDX 10'h080
`define TCR_MASK_IDX 10'h081

// Position of the word index inside the byte address.
`define TCR_ADDR_W 12
`define TCR_IDX_LSB 2
`define TCR_IDX_MSB 11

// Event status layout: end-of-count of timers 0 to 3, then capture A of timers 1 and 3.
`define TCR_EV_W 6
`define TCR_EOC_LSB 0
`define TCR_CAPA_T1_BIT 4
`define TCR_CAPA_T3_BIT 5

// Synchronised pin order.
`define TCR_PIN_W 4
`define TCR_PIN_CAP_T1 0
`define TCR_PIN_CAP_T3 1
`define TCR_PIN_TRIP_T1 2
`define TCR_PIN_TRIP_T3 3

// Widths and reset values.
`define TCR_BYTE_W 8
`define TCR_CNT_W 16
`define TCR_DATA_W 32
`define TCR_BYTE_ZERO 8'h00
`define TCR_CNT_ZERO 16'h0000
`define TCR_EV_ZERO 6'h00
`define TCR_PIN_ZERO 4'h0
`define TCR_WORD_ZERO 32'h00000000
`define TCR_PAD_ZERO 24'h000000
`define TCR_EV_PAD 26'h0000000

`endif
